// ===== logic/mad_top.sv
// Activity and inactivity detection for a three-axis sample stream.
// Assumes samples, register requests and status reads share core_clk.
//
// Summary of operation
// - Compare magnitude of each signed 12-bit axis against 11-bit motion limit.
// - Motion limit is low byte plus three low bits of high register.
// - Limits are raw codes, no rescaling for the measurement range.
// - Motion event after dwell count of consecutive samples with any axis above.
// - Motion dwell of zero acts like one.
// - In wake-up mode motion dwell is ignored; one sample suffices.
// - Stillness limit is 11 bits, low byte plus three low bits of high register.
// - Stillness event after 16-bit count of samples with all axes below.
// - Stillness dwell is low register bits 7-0, high register bits 15-8.
// - Stillness counter reaches the full 16-bit range without early wrap.
// - Stillness dwell of zero acts like one.
// - Default sequencing: detectors independent, flags held until status read.
// - Linked: one detector armed at a time, host acknowledges by status read.
// - Loop: detectors alternate and events are acknowledged internally.
// - Linked or loop only when both detector enables are set.
// - Control bit 3 selects referenced stillness comparison.
// - Control bit 2 enables the stillness detector.
// - Control bit 1 selects referenced motion comparison.
// - Control bit 0 enables the motion detector.
// - Awake tracks state only in linked or loop, else reads one.
// - Motion flag sets on a motion event.
// - Stillness flag sets on a stillness event.
`timescale 1ns/1ns
module mad_top (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic soft_rst,
    input wire logic wake_mode,
    input wire mad_pkg::mad_reg_req_t reg_req,
    input wire logic status_read,
    input wire logic sample_valid,
    input wire mad_pkg::mad_sample_t sample,
    output logic [7:0] reg_rdata_q,
    output logic motion_flag_q,
    output logic stillness_flag_q,
    output logic awake_q,
    output logic motion_armed_q,
    output logic stillness_armed_q,
    output logic motion_event_q,
    output logic stillness_event_q
);

    ////////////////////////////////////////////////////////////////////////////////
    // Types of the detector state

    typedef struct packed {
        mad_pkg::mad_arm_t arm;
        logic [mad_pkg::MAD_MOTION_DWELL_W-1:0] motion_cnt;
        logic [mad_pkg::MAD_STILL_DWELL_W-1:0] still_cnt;
        logic motion_armed;
        logic still_armed;
        logic motion_flag;
        logic still_flag;
        logic awake;
        logic motion_event;
        logic still_event;
        mad_pkg::mad_sample_t last;
        mad_pkg::mad_sample_t motion_ref;
        mad_pkg::mad_sample_t still_ref;
    } mad_state_t;

    localparam mad_state_t MAD_STATE_RESET = '{
        arm: mad_pkg::MAD_ARM_MOTION,
        motion_cnt: '0,
        still_cnt: '0,
        motion_armed: 1'b0,
        still_armed: 1'b0,
        motion_flag: 1'b0,
        still_flag: 1'b0,
        awake: mad_pkg::MAD_AWAKE_RESET,
        motion_event: 1'b0,
        still_event: 1'b0,
        last: '0,
        motion_ref: '0,
        still_ref: '0
    };

    ////////////////////////////////////////////////////////////////////////////////
    // Registers

    mad_pkg::mad_cfg_t cfg;

    mad_regs u_regs (
        .core_clk(core_clk),
        .rst(rst),
        .ce(ce),
        .soft_rst(soft_rst),
        .req(reg_req),
        .rdata_q(reg_rdata_q),
        .cfg(cfg)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Control decode

    logic motion_on;
    logic still_on;
    logic motion_rel;
    logic still_rel;
    mad_pkg::mad_seq_t seq;

    assign motion_on = cfg.control[mad_pkg::MAD_CTL_MOTION_ON];
    assign still_on = cfg.control[mad_pkg::MAD_CTL_STILL_ON];
    assign motion_rel = cfg.control[mad_pkg::MAD_CTL_MOTION_REL];
    assign still_rel = cfg.control[mad_pkg::MAD_CTL_STILL_REL];

    always_comb begin
        if (!(motion_on && still_on) || !cfg.control[mad_pkg::MAD_CTL_SEQ_LINK]) begin
            seq = mad_pkg::MAD_SEQ_DEFAULT;
        end else if (cfg.control[mad_pkg::MAD_CTL_SEQ_LOOP]) begin
            seq = mad_pkg::MAD_SEQ_LOOP;
        end else begin
            seq = mad_pkg::MAD_SEQ_LINKED;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Per-axis comparison

    mad_state_t st_q;
    mad_state_t st_d;
    logic [mad_pkg::MAD_AXES-1:0] axis_above;
    logic [mad_pkg::MAD_AXES-1:0] axis_below;

    for (genvar a = 0; a < mad_pkg::MAD_AXES; a++) begin : g_axis
        mad_axis_cmp u_cmp (
            .sample(sample.axis[a]),
            .motion_ref(st_q.motion_ref.axis[a]),
            .stillness_ref(st_q.still_ref.axis[a]),
            .motion_relative_sel(motion_rel),
            .stillness_relative_sel(still_rel),
            .motion_limit(cfg.motion_limit),
            .stillness_limit(cfg.stillness_limit),
            .above(axis_above[a]),
            .below(axis_below[a])
        );
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Arming and dwell targets

    localparam logic [mad_pkg::MAD_MOTION_DWELL_W-1:0] MAD_ONE_MOTION = 8'h01;
    localparam logic [mad_pkg::MAD_STILL_DWELL_W-1:0] MAD_ONE_STILL = 16'h0001;

    logic motion_arm;
    logic still_arm;
    logic [mad_pkg::MAD_MOTION_DWELL_W-1:0] motion_target;
    logic [mad_pkg::MAD_STILL_DWELL_W-1:0] still_target;
    logic [mad_pkg::MAD_MOTION_DWELL_W-1:0] motion_next;
    logic [mad_pkg::MAD_STILL_DWELL_W-1:0] still_next;
    logic motion_hit;
    logic still_hit;
    logic motion_fire;
    logic still_fire;

    always_comb begin
        if (seq == mad_pkg::MAD_SEQ_DEFAULT) begin
            motion_arm = motion_on;
            still_arm = still_on;
        end else begin
            motion_arm = st_q.arm == mad_pkg::MAD_ARM_MOTION;
            still_arm = st_q.arm == mad_pkg::MAD_ARM_STILL;
        end
    end

    always_comb begin
        motion_target = cfg.motion_dwell;
        if (wake_mode || cfg.motion_dwell == '0) begin
            motion_target = MAD_ONE_MOTION;
        end
        still_target = cfg.stillness_dwell;
        if (cfg.stillness_dwell == '0) begin
            still_target = MAD_ONE_STILL;
        end
    end

    // Counter never exceeds the largest target minus one, so the increment cannot wrap
    assign motion_next = st_q.motion_cnt + MAD_ONE_MOTION;
    assign still_next = st_q.still_cnt + MAD_ONE_STILL;
    assign motion_hit = sample_valid && motion_arm && (|axis_above);
    assign still_hit = sample_valid && still_arm && (&axis_below);
    assign motion_fire = motion_hit && (motion_next >= motion_target);
    assign still_fire = still_hit && (still_next >= still_target);

    ////////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        st_d = st_q;
        st_d.motion_event = motion_fire;
        st_d.still_event = still_fire;
        st_d.motion_armed = motion_arm;
        st_d.still_armed = still_arm;

        if (sample_valid) begin
            st_d.last = sample;
        end

        // Reference taken from the newest sample seen before arming
        if (motion_arm && !st_q.motion_armed) begin
            st_d.motion_ref = st_q.last;
        end
        if (still_arm && !st_q.still_armed) begin
            st_d.still_ref = st_q.last;
        end

        if (!motion_arm) begin
            st_d.motion_cnt = '0;
        end else if (sample_valid) begin
            st_d.motion_cnt = (motion_hit && !motion_fire) ? motion_next : '0;
        end
        if (!still_arm) begin
            st_d.still_cnt = '0;
        end else if (sample_valid) begin
            st_d.still_cnt = (still_hit && !still_fire) ? still_next : '0;
        end

        // Host status read clears; a same-cycle event still sets
        if (status_read) begin
            st_d.motion_flag = 1'b0;
            st_d.still_flag = 1'b0;
        end
        if (seq == mad_pkg::MAD_SEQ_LOOP) begin
            if (still_fire) begin
                st_d.motion_flag = 1'b0;
            end
            if (motion_fire) begin
                st_d.still_flag = 1'b0;
            end
        end
        if (motion_fire) begin
            st_d.motion_flag = 1'b1;
        end
        if (still_fire) begin
            st_d.still_flag = 1'b1;
        end

        // Sequencing alternates the armed detector; default parks on motion
        unique case (seq)
            mad_pkg::MAD_SEQ_DEFAULT: begin
                st_d.arm = mad_pkg::MAD_ARM_MOTION;
            end
            mad_pkg::MAD_SEQ_LINKED, mad_pkg::MAD_SEQ_LOOP: begin
                if (motion_fire) begin
                    st_d.arm = mad_pkg::MAD_ARM_STILL;
                end else if (still_fire) begin
                    st_d.arm = mad_pkg::MAD_ARM_MOTION;
                end
            end
            default: begin
                st_d.arm = mad_pkg::MAD_ARM_MOTION;
            end
        endcase

        if (seq == mad_pkg::MAD_SEQ_DEFAULT) begin
            st_d.awake = mad_pkg::MAD_AWAKE_RESET;
        end else begin
            st_d.awake = st_d.arm == mad_pkg::MAD_ARM_STILL;
        end

        if (soft_rst) begin
            st_d = MAD_STATE_RESET;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_q <= MAD_STATE_RESET;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign motion_flag_q = st_q.motion_flag;
    assign stillness_flag_q = st_q.still_flag;
    assign awake_q = st_q.awake;
    assign motion_armed_q = st_q.motion_armed;
    assign stillness_armed_q = st_q.still_armed;
    assign motion_event_q = st_q.motion_event;
    assign stillness_event_q = st_q.still_event;

endmodule // mad_top

// ===== include/mad_pkg.sv
// Shared constants and types of the motion activity detector.
// Assumes a single 100 MHz core clock and an on-chip register port.
package mad_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Geometry
    localparam int unsigned MAD_AXES = 3;
    localparam int unsigned MAD_SAMPLE_W = 12;
    localparam int unsigned MAD_LIMIT_W = 11;
    localparam int unsigned MAD_MOTION_DWELL_W = 8;
    localparam int unsigned MAD_STILL_DWELL_W = 16;
    localparam int unsigned MAD_REG_COUNT = 8;
    localparam int unsigned MAD_REG_IDX_W = 3;

    ////////////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [7:0] MAD_OFS_MOTION_LIMIT_LO = 8'h20;
    localparam logic [7:0] MAD_OFS_MOTION_LIMIT_HI = 8'h21;
    localparam logic [7:0] MAD_OFS_MOTION_DWELL = 8'h22;
    localparam logic [7:0] MAD_OFS_STILL_LIMIT_LO = 8'h23;
    localparam logic [7:0] MAD_OFS_STILL_LIMIT_HI = 8'h24;
    localparam logic [7:0] MAD_OFS_STILL_DWELL_LO = 8'h25;
    localparam logic [7:0] MAD_OFS_STILL_DWELL_HI = 8'h26;
    localparam logic [7:0] MAD_OFS_CONTROL = 8'h27;
    localparam logic [7:0] MAD_REG_RESET = 8'h00;
    localparam logic [7:0] MAD_READ_UNMAPPED = 8'h00;

    ////////////////////////////////////////////////////////////////////////////////
    // Control register fields
    localparam int unsigned MAD_CTL_MOTION_ON = 0;
    localparam int unsigned MAD_CTL_MOTION_REL = 1;
    localparam int unsigned MAD_CTL_STILL_ON = 2;
    localparam int unsigned MAD_CTL_STILL_REL = 3;
    localparam int unsigned MAD_CTL_SEQ_LINK = 4;
    localparam int unsigned MAD_CTL_SEQ_LOOP = 5;
    localparam logic MAD_AWAKE_RESET = 1'b1;

    ////////////////////////////////////////////////////////////////////////////////
    // Types
    typedef struct packed {
        logic [MAD_AXES-1:0][MAD_SAMPLE_W-1:0] axis;
    } mad_sample_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } mad_reg_req_t;

    typedef struct packed {
        logic [MAD_LIMIT_W-1:0] motion_limit;
        logic [MAD_LIMIT_W-1:0] stillness_limit;
        logic [MAD_MOTION_DWELL_W-1:0] motion_dwell;
        logic [MAD_STILL_DWELL_W-1:0] stillness_dwell;
        logic [7:0] control;
    } mad_cfg_t;

    typedef enum logic {
        MAD_ARM_MOTION,
        MAD_ARM_STILL
    } mad_arm_t;

    typedef enum logic [1:0] {
        MAD_SEQ_DEFAULT,
        MAD_SEQ_LINKED,
        MAD_SEQ_LOOP
    } mad_seq_t;

endpackage

// ===== logic/mad_regs.sv
// Register file of the motion activity detector: eight byte registers.
// Assumes requests come from serial-port logic on the same clock.
`timescale 1ns/1ns
module mad_regs (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic soft_rst,
    input wire mad_pkg::mad_reg_req_t req,
    output logic [7:0] rdata_q,
    output mad_pkg::mad_cfg_t cfg
);

    logic [7:0] regs_q [mad_pkg::MAD_REG_COUNT];
    logic [7:0] regs_d [mad_pkg::MAD_REG_COUNT];
    logic [7:0] rdata_d;
    logic hit;
    logic [mad_pkg::MAD_REG_IDX_W-1:0] idx;

    ////////////////////////////////////////////////////////////////////////////////
    // Decode, write and registered read
    assign hit = (req.addr >= mad_pkg::MAD_OFS_MOTION_LIMIT_LO)
               && (req.addr <= mad_pkg::MAD_OFS_CONTROL);
    assign idx = req.addr[mad_pkg::MAD_REG_IDX_W-1:0];

    always_comb begin
        regs_d = regs_q;
        rdata_d = rdata_q;
        if (soft_rst) begin
            for (int i = 0; i < mad_pkg::MAD_REG_COUNT; i++) begin
                regs_d[i] = mad_pkg::MAD_REG_RESET;
            end
        end else if (req.wr && hit) begin
            regs_d[idx] = req.wdata;
        end
        if (req.rd) begin
            rdata_d = hit ? regs_q[idx] : mad_pkg::MAD_READ_UNMAPPED;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < mad_pkg::MAD_REG_COUNT; i++) begin
                regs_q[i] <= mad_pkg::MAD_REG_RESET;
            end
            rdata_q <= mad_pkg::MAD_REG_RESET;
        end else if (ce) begin
            regs_q <= regs_d;
            rdata_q <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Field assembly; unused high bits are stored but ignored
    assign cfg.motion_limit = {regs_q[1][2:0], regs_q[0]};
    assign cfg.stillness_limit = {regs_q[4][2:0], regs_q[3]};
    assign cfg.motion_dwell = regs_q[2];
    assign cfg.stillness_dwell = {regs_q[6], regs_q[5]};
    assign cfg.control = regs_q[7];

endmodule // mad_regs

// ===== logic/mad_axis_cmp.sv
// One axis of the comparator: magnitude against both limits.
// Assumes sample and reference are two's complement 12-bit codes.
`timescale 1ns/1ns
module mad_axis_cmp (
    input wire logic [11:0] sample,
    input wire logic [11:0] motion_ref,
    input wire logic [11:0] stillness_ref,
    input wire logic motion_relative_sel,
    input wire logic stillness_relative_sel,
    input wire logic [10:0] motion_limit,
    input wire logic [10:0] stillness_limit,
    output logic above,
    output logic below
);

    logic signed [12:0] motion_diff;
    logic signed [12:0] still_diff;
    logic [12:0] motion_mag;
    logic [12:0] still_mag;

    // One extra bit keeps -2048 and referenced differences from overflowing
    always_comb begin
        motion_diff = $signed({sample[11], sample});
        still_diff = $signed({sample[11], sample});
        if (motion_relative_sel) begin
            motion_diff = $signed({sample[11], sample}) - $signed({motion_ref[11], motion_ref});
        end
        if (stillness_relative_sel) begin
            still_diff = $signed({sample[11], sample}) - $signed({stillness_ref[11], stillness_ref});
        end
        motion_mag = motion_diff[12] ? 13'(-motion_diff) : 13'(motion_diff);
        still_mag = still_diff[12] ? 13'(-still_diff) : 13'(still_diff);
        above = motion_mag > {2'h0, motion_limit};
        below = still_mag < {2'h0, stillness_limit};
    end

endmodule // mad_axis_cmp

// ===== sim/mad_monitor.sv
// Port checker of the motion activity detector.
// Assumes binding to mad_top; sees its ports only, one clock domain.
`timescale 1ns/1ns
module mad_monitor (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic soft_rst,
    input wire logic wake_mode,
    input wire mad_pkg::mad_reg_req_t reg_req,
    input wire logic status_read,
    input wire logic sample_valid,
    input wire mad_pkg::mad_sample_t sample,
    input wire logic [7:0] reg_rdata_q,
    input wire logic motion_flag_q,
    input wire logic stillness_flag_q,
    input wire logic awake_q,
    input wire logic motion_armed_q,
    input wire logic stillness_armed_q,
    input wire logic motion_event_q,
    input wire logic stillness_event_q
);
    ////////////////////////////////////////////////////////////////////////////////
    // Shadow of the control register, rebuilt from the write strobes
    logic [7:0] ctl_q;
    logic [7:0] ctl_d;
    logic lnk;
    logic lp;
    always_comb begin
        ctl_d = ctl_q;
        if (ce && soft_rst) ctl_d = 8'h00;
        else if (ce && reg_req.wr && reg_req.addr == mad_pkg::MAD_OFS_CONTROL) ctl_d = reg_req.wdata;
    end
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) ctl_q <= 8'h00;
        else ctl_q <= ctl_d;
    end
    assign lnk = ctl_q[0] && ctl_q[2] && ctl_q[4];
    assign lp = lnk && ctl_q[5];

    ////////////////////////////////////////////////////////////////////////////////
    // Three held cycles cover the one-cycle lag of the arm registers
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_linked_held;
        lnk [*3];
    endsequence
    sequence s_loop_held;
        lp [*3];
    endsequence
    sequence s_default_held;
        !lnk [*3];
    endsequence

    a_motion_flag_set: assert property (motion_event_q |-> motion_flag_q)
        else $error("motion event without motion flag");
    a_still_flag_set: assert property (stillness_event_q |-> stillness_flag_q)
        else $error("stillness event without stillness flag");
    a_awake_default_one: assert property (s_default_held |-> awake_q)
        else $error("awake low outside linked or loop");
    a_still_off_quiet: assert property (!$past(ctl_q[2]) && !ctl_q[2] |-> !stillness_event_q)
        else $error("stillness event while disabled");
    a_motion_off_quiet: assert property (!$past(ctl_q[0]) && !ctl_q[0] |-> !motion_event_q)
        else $error("motion event while disabled");
    a_status_read_clears: assert property (ce && status_read |=>
        (!motion_flag_q || motion_event_q) && (!stillness_flag_q || stillness_event_q))
        else $error("flag survived status read");
    a_one_armed_linked: assert property (s_linked_held |-> !(motion_armed_q && stillness_armed_q))
        else $error("both detectors armed in linked mode");
    a_loop_self_ack: assert property (s_loop_held ##0 stillness_event_q |-> !motion_flag_q)
        else $error("motion flag kept in loop mode");
    a_unmapped_reads_zero: assert property (ce && reg_req.rd && !soft_rst &&
        (reg_req.addr < mad_pkg::MAD_OFS_MOTION_LIMIT_LO || reg_req.addr > mad_pkg::MAD_OFS_CONTROL)
        |=> reg_rdata_q == 8'h00)
        else $error("unmapped read not zero");
    a_read_data_holds: assert property (!(ce && (reg_req.rd || soft_rst)) |=> $stable(reg_rdata_q))
        else $error("read data changed without a read");
endmodule // mad_monitor

bind mad_top mad_monitor u_mon (.core_clk(core_clk), .rst(rst), .ce(ce), .soft_rst(soft_rst),
    .wake_mode(wake_mode), .reg_req(reg_req), .status_read(status_read),
    .sample_valid(sample_valid), .sample(sample), .reg_rdata_q(reg_rdata_q),
    .motion_flag_q(motion_flag_q), .stillness_flag_q(stillness_flag_q), .awake_q(awake_q),
    .motion_armed_q(motion_armed_q), .stillness_armed_q(stillness_armed_q),
    .motion_event_q(motion_event_q), .stillness_event_q(stillness_event_q));

// ===== sim/mad_host_model.sv
// Host processor model: register writes, reads and status acknowledges.
// Assumes the same core_clk as the detector; tasks are called by the bench.
`timescale 1ns/1ns
module mad_host_model (
    input wire logic core_clk,
    input wire logic [7:0] reg_rdata_q,
    output mad_pkg::mad_reg_req_t reg_req,
    output logic status_read
);
    initial begin
        reg_req = '0;
        status_read = 1'b0;
    end

    // Released address and data are inverted so nothing relies on stale values
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        reg_req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    endtask

    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        reg_req <= '{addr: ~a, wdata: 8'hff, wr: 1'b0, rd: 1'b0};
        @(negedge core_clk);
        d = reg_rdata_q;
    endtask

    // Each event is acknowledged by a status read in default and linked modes
    task automatic ack_status();
        @(posedge core_clk);
        status_read <= 1'b1;
        @(posedge core_clk);
        status_read <= 1'b0;
        @(negedge core_clk);
    endtask
endmodule // mad_host_model

// ===== sim/tb.sv
// Self-checking bench of the motion activity detector.
// Assumes the host model for register traffic; samples come from here.
`timescale 1ns/1ns
module tb;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic soft_rst = 1'b0;
    logic wake_mode = 1'b0;
    logic sample_valid = 1'b0;
    mad_pkg::mad_sample_t sample = '0;
    mad_pkg::mad_reg_req_t reg_req;
    logic status_read;
    logic [7:0] reg_rdata_q;
    logic motion_flag_q, stillness_flag_q, awake_q;
    logic motion_armed_q, stillness_armed_q, motion_event_q, stillness_event_q;
    int mismatches = 0;
    int samples_checked = 0;
    int cycles = 0;
    int mev = 0;
    int sev = 0;

    always #5 core_clk = ~core_clk;

    mad_top uut (.core_clk(core_clk), .rst(rst), .ce(ce), .soft_rst(soft_rst),
        .wake_mode(wake_mode), .reg_req(reg_req), .status_read(status_read),
        .sample_valid(sample_valid), .sample(sample), .reg_rdata_q(reg_rdata_q),
        .motion_flag_q(motion_flag_q), .stillness_flag_q(stillness_flag_q), .awake_q(awake_q),
        .motion_armed_q(motion_armed_q), .stillness_armed_q(stillness_armed_q),
        .motion_event_q(motion_event_q), .stillness_event_q(stillness_event_q));
    mad_host_model host (.core_clk(core_clk), .reg_rdata_q(reg_rdata_q), .reg_req(reg_req),
        .status_read(status_read));

    ////////////////////////////////////////////////////////////////////////////////
    // Events are one-cycle pulses, so they are counted away from the clock edge
    always @(negedge core_clk) begin
        if (motion_event_q === 1'b1) mev++;
        if (stillness_event_q === 1'b1) sev++;
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host.read_reg(a, d);
        chk({8'h00, d}, {8'h00, exp});
    endtask

    // Bytes for 0x20 up to 0x27, lowest byte first
    task automatic setr(input logic [63:0] v);
        for (int i = 0; i < 8; i++) host.write_reg(8'h20 + 8'(i), v[8*i +: 8]);
    endtask

    task automatic smp(input logic [11:0] x, input logic [11:0] y, input logic [11:0] z);
        @(posedge core_clk);
        sample_valid <= 1'b1;
        sample <= '{axis: {z, y, x}};
        @(posedge core_clk);
        sample_valid <= 1'b0;
        sample <= '{axis: {~z, ~y, ~x}};
    endtask

    task automatic ev(input logic [15:0] em, input logic [15:0] es);
        repeat (4) @(posedge core_clk);
        chk(16'(mev), em);
        chk(16'(sev), es);
        mev = 0;
        sev = 0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++) rchk(8'h20 + 8'(i), 8'h00);
        chk({15'h0, awake_q}, 16'h1);
        setr(64'h88_87_86_85_84_83_82_81);
        for (int i = 0; i < 8; i++) rchk(8'h20 + 8'(i), 8'h81 + 8'(i));
        host.write_reg(8'h28, 8'h5a);
        rchk(8'h28, 8'h00);
        $display("test registers done");
        // Upper bits of the high limit byte must be dropped: limit 0x534
        setr(64'h01_00_00_01_00_00_fd_34);
        smp(12'h534, 12'h000, 12'h000);
        ev(16'h0, 16'h0);
        smp(12'h000, 12'h000, 12'hacb);
        ev(16'h1, 16'h0);
        host.write_reg(8'h22, 8'h03);
        smp(12'hacb, 12'h0, 12'h0);
        smp(12'hacb, 12'h0, 12'h0);
        smp(12'h010, 12'h0, 12'h0);
        smp(12'hacb, 12'h0, 12'h0);
        smp(12'hacb, 12'h0, 12'h0);
        ev(16'h0, 16'h0);
        smp(12'hacb, 12'h0, 12'h0);
        ev(16'h1, 16'h0);
        wake_mode <= 1'b1;
        smp(12'h0, 12'h535, 12'h0);
        ev(16'h1, 16'h0);
        wake_mode <= 1'b0;
        chk({15'h0, motion_flag_q}, 16'h1);
        host.ack_status();
        chk({15'h0, motion_flag_q}, 16'h0);
        $display("test motion done");
        // Stillness limit 0x100 and dwell 0x0102
        setr(64'h04_01_02_01_00_00_fd_34);
        smp(12'h000, 12'h100, 12'h000);
        repeat (257) smp(12'h0ff, 12'hf01, 12'h000);
        ev(16'h0, 16'h0);
        smp(12'h0ff, 12'hf01, 12'h000);
        ev(16'h0, 16'h1);
        chk({15'h0, stillness_flag_q}, 16'h1);
        host.write_reg(8'h25, 8'h00);
        host.write_reg(8'h26, 8'h00);
        smp(12'h000, 12'h000, 12'h0ff);
        ev(16'h0, 16'h1);
        host.write_reg(8'h27, 8'h0a);
        smp(12'hacb, 12'h0, 12'h0);
        smp(12'h0, 12'h0, 12'h0);
        ev(16'h0, 16'h0);
        $display("test stillness done");
        host.ack_status();
        host.write_reg(8'h27, 8'h15);
        repeat (3) @(posedge core_clk);
        chk({15'h0, awake_q}, 16'h0);
        smp(12'hacb, 12'h0, 12'h0);
        ev(16'h1, 16'h0);
        chk({15'h0, awake_q}, 16'h1);
        smp(12'h0, 12'h0, 12'h0);
        ev(16'h0, 16'h1);
        chk({14'h0, motion_flag_q, stillness_flag_q}, 16'h3);
        host.ack_status();
        chk({14'h0, motion_flag_q, stillness_flag_q}, 16'h0);
        host.write_reg(8'h27, 8'h11);
        repeat (3) @(posedge core_clk);
        chk({15'h0, awake_q}, 16'h1);
        host.write_reg(8'h27, 8'h35);
        smp(12'hacb, 12'h0, 12'h0);
        smp(12'h0, 12'h0, 12'h0);
        ev(16'h1, 16'h1);
        chk({14'h0, motion_flag_q, stillness_flag_q}, 16'h1);
        $display("test sequencing done");
        // A reference of 1000 makes -400 a swing of 1400, and 1008 a swing of 8
        host.ack_status();
        host.write_reg(8'h27, 8'h00);
        smp(12'h3e8, 12'h0, 12'h0);
        host.write_reg(8'h27, 8'h03);
        repeat (3) @(posedge core_clk);
        smp(12'h3e8, 12'h0, 12'h0);
        ev(16'h0, 16'h0);
        smp(12'he70, 12'h0, 12'h0);
        ev(16'h1, 16'h0);
        host.write_reg(8'h27, 8'h00);
        smp(12'h3e8, 12'h0, 12'h0);
        host.write_reg(8'h27, 8'h0c);
        repeat (3) @(posedge core_clk);
        smp(12'h3f0, 12'h0, 12'h0);
        ev(16'h0, 16'h1);
        ce <= 1'b0;
        smp(12'h3f0, 12'h0, 12'h0);
        ce <= 1'b1;
        ev(16'h0, 16'h0);
        @(posedge core_clk);
        soft_rst <= 1'b1;
        @(posedge core_clk);
        soft_rst <= 1'b0;
        rchk(8'h27, 8'h00);
        chk({15'h0, awake_q}, 16'h1);
        $display("test reference done");
        end_sim();
    end
endmodule // tb
